// ===== hw/bypass_pwm_pkg.sv
/*
 Constants shared by the bypass-switch PWM matrix: register offsets, field positions,
 reset values and sizes.
 Assumes a single 20 MHz clock domain.
// Behaviour
// - Reset loads every register with defaults
// - After reset all bypass switches conduct
// - Supply and core undervoltage together reset registers
// - Switch off lights LED, on darkens
// - Global enable resets 0, gates duty following
// - Serial activity suspends spread-spectrum modulation
// - External clock drives PWM, spread only pump
// - Bus address equals 4-bit address decode
// - Pin voltage quantized into sixteen levels
// - Binning pin decoded with same table
// - One shared 12-bit dimming counter
// - Off at delay, on after delay plus duty
// - Separate delay and duty per switch
*/
package bypass_pwm_pkg;
	localparam int SWITCHES = 12;
	localparam int COUNT_W = 12;
	localparam int CODE_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] REG_SWITCH_GO_CONTROL = 8'h01;
	localparam logic [7:0] REG_GEN = 8'h02;
	localparam logic [7:0] REG_PINS = 8'h03;
	localparam logic [7:0] REG_PHASE_BASE = 8'h20;
	localparam logic [7:0] REG_DUTY_BASE = 8'h40;
	localparam int GO_BIT = 0;
	localparam int EXT_CLK_BIT = 0;
	localparam int SPREAD_BIT = 1;
	localparam logic [7:0] SWITCH_GO_CONTROL_RESET = 8'h00;
	localparam logic [7:0] GEN_RESET = 8'h00;
	localparam logic [11:0] PHASE_RESET = 12'h000;
	localparam logic [11:0] DUTY_RESET = 12'h000;
	localparam logic [11:0] COUNT_MAX = 12'hFFF;
	localparam int SYNC_STAGES = 2;
endpackage

// ===== hw/pin_level_decode.sv
/*
 Quantizes a 12-bit pin-voltage sample into one of sixteen 4-bit levels.
 Assumes the sample is full scale at 1.2 V and already on clk_in.
*/
`timescale 1ns/1ps
module pin_level_decode #(
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Sample and code
	input wire logic [SAMPLE_W-1:0] sample_in,
	output logic [3:0] code_out
);
	initial begin
		if (SAMPLE_W < 4) $error("SAMPLE_W too small");
	end

	// Top four bits give sixteen equal bands over 0 to 1.2 V
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			code_out <= 4'h0;
		end else begin
			code_out <= sample_in[SAMPLE_W-1 -: 4];
		end
	end
endmodule // pin_level_decode

// ===== hw/led_bypass_pwm_matrix.sv
/*
 Twelve-channel bypass-switch PWM matrix: register file, shared dimming counter,
 per-switch phase/duty compare, pin decode and spread-spectrum gating.
 Assumes a serial front end delivering single-cycle register write/read strobes,
 and a converter delivering pin-voltage samples from the external domain.
*/
`timescale 1ns/1ps
module led_bypass_pwm_matrix #(
	parameter int SWITCHES = bypass_pwm_pkg::SWITCHES,
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Supply monitors
	input wire logic input_reset_threshold_low_in,
	input wire logic core_undervoltage_lockout_in,
	// Register access from the serial front end
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic serial_busy_in,
	// Clocking
	input wire logic ext_clk_tick_in,
	input wire logic ext_clk_present_in,
	input wire logic int_clk_tick_in,
	output logic spread_enable_out,
	// Resistor pins
	input wire logic [SAMPLE_W-1:0] address_resistor_pin_in,
	input wire logic [SAMPLE_W-1:0] binning_resistor_pin_in,
	output logic [3:0] device_address_out,
	output logic [3:0] binning_code_out,
	// Bypass switch gates, 1 = conducting
	output logic [SWITCHES-1:0] bypass_on_out
);
	initial begin
		if (SWITCHES < 1 || SWITCHES > 16) $error("SWITCHES out of range");
	end

	logic [1:0] vin_sync;
	logic [1:0] core_sync;
	logic [1:0] ext_sync;
	logic [2:0] tick_sync;
	logic [1:0] busy_sync;
	logic soft_reset;
	logic [7:0] switch_go_control;
	logic [7:0] gen_config;
	logic global_switch_enable;
	logic use_ext;
	logic pwm_tick;
	logic [11:0] count;
	logic [11:0] phase_delay [SWITCHES];
	logic [11:0] duty [SWITCHES];
	logic [SWITCHES-1:0] next_bypass;
	logic [SAMPLE_W-1:0] addr_s1;
	logic [SAMPLE_W-1:0] addr_s2;
	logic [SAMPLE_W-1:0] bin_s1;
	logic [SAMPLE_W-1:0] bin_s2;
	logic [SAMPLE_W-1:0] addr_s3;
	logic [SAMPLE_W-1:0] bin_s3;
	logic [SAMPLE_W-1:0] addr_held;
	logic [SAMPLE_W-1:0] bin_held;
	logic [SAMPLE_W-1:0] addr_sample;
	logic [SAMPLE_W-1:0] bin_sample;

	// Two-stage synchronisers for asynchronous monitors and pins
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			vin_sync <= 2'h0;
			core_sync <= 2'h0;
			ext_sync <= 2'h0;
			tick_sync <= 3'h0;
			busy_sync <= 2'h0;
			addr_s1 <= '0;
			addr_s2 <= '0;
			addr_s3 <= '0;
			bin_s1 <= '0;
			bin_s2 <= '0;
			bin_s3 <= '0;
		end else begin
			vin_sync <= {vin_sync[0], input_reset_threshold_low_in};
			core_sync <= {core_sync[0], core_undervoltage_lockout_in};
			ext_sync <= {ext_sync[0], ext_clk_present_in};
			tick_sync <= {tick_sync[1:0], ext_clk_tick_in};
			busy_sync <= {busy_sync[0], serial_busy_in};
			addr_s1 <= address_resistor_pin_in;
			addr_s2 <= addr_s1;
			addr_s3 <= addr_s2;
			bin_s1 <= binning_resistor_pin_in;
			bin_s2 <= bin_s1;
			bin_s3 <= bin_s2;
		end
	end

	// Each monitor is synchronised on its own before the two are combined
	assign soft_reset = vin_sync[1] & core_sync[1];

	// A pin word is passed on only while two synchronised samples agree,
	// so a word caught mid-change never reaches the decoder
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_held <= '0;
			bin_held <= '0;
		end else begin
			if (addr_s2 == addr_s3) begin
				addr_held <= addr_s2;
			end
			if (bin_s2 == bin_s3) begin
				bin_held <= bin_s2;
			end
		end
	end

	assign addr_sample = (addr_s2 == addr_s3) ? addr_s2 : addr_held;
	assign bin_sample = (bin_s2 == bin_s3) ? bin_s2 : bin_held;

	// Register file; reset and undervoltage restore defaults
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			switch_go_control <= bypass_pwm_pkg::SWITCH_GO_CONTROL_RESET;
			gen_config <= bypass_pwm_pkg::GEN_RESET;
		end else if (soft_reset) begin
			switch_go_control <= bypass_pwm_pkg::SWITCH_GO_CONTROL_RESET;
			gen_config <= bypass_pwm_pkg::GEN_RESET;
		end else if (reg_write_in) begin
			if (reg_addr_in == bypass_pwm_pkg::REG_SWITCH_GO_CONTROL) begin
				switch_go_control <= reg_wdata_in;
			end
			if (reg_addr_in == bypass_pwm_pkg::REG_GEN) begin
				gen_config <= reg_wdata_in;
			end
		end
	end

	// Per-switch phase and duty, low byte at base+2n, high nibble at base+2n+1
	genvar g;
	generate
		for (g = 0; g < SWITCHES; g++) begin : g_sw
			localparam logic [7:0] PH_LO = bypass_pwm_pkg::REG_PHASE_BASE + 8'(2 * g);
			localparam logic [7:0] DU_LO = bypass_pwm_pkg::REG_DUTY_BASE + 8'(2 * g);
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					phase_delay[g] <= bypass_pwm_pkg::PHASE_RESET;
					duty[g] <= bypass_pwm_pkg::DUTY_RESET;
				end else if (soft_reset) begin
					phase_delay[g] <= bypass_pwm_pkg::PHASE_RESET;
					duty[g] <= bypass_pwm_pkg::DUTY_RESET;
				end else if (reg_write_in) begin
					if (reg_addr_in == PH_LO) phase_delay[g][7:0] <= reg_wdata_in;
					if (reg_addr_in == PH_LO + 8'h01) phase_delay[g][11:8] <= reg_wdata_in[3:0];
					if (reg_addr_in == DU_LO) duty[g][7:0] <= reg_wdata_in;
					if (reg_addr_in == DU_LO + 8'h01) duty[g][11:8] <= reg_wdata_in[3:0];
				end
			end

			// Off from count == delay until count > delay + duty; never off while duty is 0
			always_comb begin
				logic [12:0] stop;
				stop = {1'b0, phase_delay[g]} + {1'b0, duty[g]};
				next_bypass[g] = bypass_on_out[g];
				if (!global_switch_enable) begin
					next_bypass[g] = 1'b1;
				end else if (pwm_tick) begin
					if (duty[g] != 12'h000 && count == phase_delay[g]) begin
						next_bypass[g] = 1'b0;
					end else if ({1'b0, count} > stop) begin
						next_bypass[g] = 1'b1;
					end
				end
			end
		end
	endgenerate

	assign global_switch_enable = switch_go_control[bypass_pwm_pkg::GO_BIT];
	assign use_ext = gen_config[bypass_pwm_pkg::EXT_CLK_BIT] & ext_sync[1];

	// PWM time base: external tick when selected and present, else internal
	assign pwm_tick = use_ext ? (tick_sync[1] & ~tick_sync[2]) : int_clk_tick_in;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count <= 12'h000;
		end else if (soft_reset || !global_switch_enable) begin
			count <= 12'h000;
		end else if (pwm_tick) begin
			count <= (count == bypass_pwm_pkg::COUNT_MAX) ? 12'h000 : count + 12'h001;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bypass_on_out <= '1;
		end else if (soft_reset) begin
			bypass_on_out <= '1;
		end else begin
			bypass_on_out <= next_bypass;
		end
	end

	// Spread spectrum only on the pump clock, paused during serial traffic
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			spread_enable_out <= 1'b0;
		end else begin
			spread_enable_out <= gen_config[bypass_pwm_pkg::SPREAD_BIT] & ~busy_sync[1];
		end
	end

	pin_level_decode #(.SAMPLE_W(SAMPLE_W)) u_addr_dec (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.sample_in(addr_sample),
		.code_out(device_address_out)
	);

	pin_level_decode #(.SAMPLE_W(SAMPLE_W)) u_bin_dec (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.sample_in(bin_sample),
		.code_out(binning_code_out)
	);

	// Read-back
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_read_in) begin
			reg_rdata_out <= 8'h00;
			if (reg_addr_in == bypass_pwm_pkg::REG_SWITCH_GO_CONTROL) reg_rdata_out <= switch_go_control;
			if (reg_addr_in == bypass_pwm_pkg::REG_GEN) reg_rdata_out <= gen_config;
			if (reg_addr_in == bypass_pwm_pkg::REG_PINS) reg_rdata_out <= {binning_code_out, device_address_out};
			for (int i = 0; i < SWITCHES; i++) begin
				if (reg_addr_in == bypass_pwm_pkg::REG_PHASE_BASE + 8'(2 * i)) reg_rdata_out <= phase_delay[i][7:0];
				if (reg_addr_in == bypass_pwm_pkg::REG_PHASE_BASE + 8'(2 * i + 1)) reg_rdata_out <= {4'h0, phase_delay[i][11:8]};
				if (reg_addr_in == bypass_pwm_pkg::REG_DUTY_BASE + 8'(2 * i)) reg_rdata_out <= duty[i][7:0];
				if (reg_addr_in == bypass_pwm_pkg::REG_DUTY_BASE + 8'(2 * i + 1)) reg_rdata_out <= {4'h0, duty[i][11:8]};
			end
		end
	end
endmodule // led_bypass_pwm_matrix

// ===== tb/led_bypass_pwm_monitor.sv
/*
 Port-level checks for the bypass-switch PWM matrix.
 Assumes one clock and the active-low asynchronous reset of the design.
*/
`timescale 1ns/1ps
module led_bypass_pwm_monitor #(
	parameter int SWITCHES = 12,
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Design inputs
	input wire logic input_reset_threshold_low_in,
	input wire logic core_undervoltage_lockout_in,
	input wire logic reg_write_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic serial_busy_in,
	input wire logic int_clk_tick_in,
	input wire logic ext_clk_tick_in,
	input wire logic [SAMPLE_W-1:0] address_resistor_pin_in,
	input wire logic [SAMPLE_W-1:0] binning_resistor_pin_in,
	// Design outputs
	input wire logic spread_enable_out,
	input wire logic [3:0] device_address_out,
	input wire logic [3:0] binning_code_out,
	input wire logic [SWITCHES-1:0] bypass_on_out
);
	logic go;
	wire logic uv = input_reset_threshold_low_in && core_undervoltage_lockout_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// Last value written to the global enable
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			go <= 1'b0;
		else if (reg_write_in && reg_addr_in == 8'h01)
			go <= reg_wdata_in[0];
	end
	reset_dark_a: assert property ($rose(nrst_in) |-> &bypass_on_out)
		else $error("switches not all on after reset");
	go_gate_a: assert property (!go && !$past(go) && !$past(go, 2) |-> &bypass_on_out)
		else $error("switch off while enable clear");
	uv_reset_a: assert property (uv [*4] |-> &bypass_on_out)
		else $error("undervoltage left a switch off");
	busy_spread_a: assert property (serial_busy_in [*3] |=> !spread_enable_out)
		else $error("spread left on during serial traffic");
	spread_on_a: assert property (reg_write_in && reg_addr_in == 8'h02 && reg_wdata_in[1]
		##3 (!serial_busy_in && !reg_write_in && !uv) [*3] |=> spread_enable_out)
		else $error("spread not on when idle");
	quiet_hold_a: assert property ((!int_clk_tick_in && !ext_clk_tick_in && !reg_write_in && !uv) [*5]
		|=> $stable(bypass_on_out))
		else $error("switch moved without a tick");
	addr_code_a: assert property ($stable(address_resistor_pin_in) [*4]
		|-> device_address_out == address_resistor_pin_in[SAMPLE_W-1 -: 4])
		else $error("address code wrong");
	bin_code_a: assert property ($stable(binning_resistor_pin_in) [*4]
		|-> binning_code_out == binning_resistor_pin_in[SAMPLE_W-1 -: 4])
		else $error("binning code wrong");
endmodule // led_bypass_pwm_monitor

bind led_bypass_pwm_matrix led_bypass_pwm_monitor #(.SWITCHES(SWITCHES), .SAMPLE_W(SAMPLE_W)) monitor_i (
	.clk_in(clk_in),
	.nrst_in(nrst_in),
	.input_reset_threshold_low_in(input_reset_threshold_low_in),
	.core_undervoltage_lockout_in(core_undervoltage_lockout_in),
	.reg_write_in(reg_write_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.serial_busy_in(serial_busy_in),
	.int_clk_tick_in(int_clk_tick_in),
	.ext_clk_tick_in(ext_clk_tick_in),
	.address_resistor_pin_in(address_resistor_pin_in),
	.binning_resistor_pin_in(binning_resistor_pin_in),
	.spread_enable_out(spread_enable_out),
	.device_address_out(device_address_out),
	.binning_code_out(binning_code_out),
	.bypass_on_out(bypass_on_out)
);

// ===== tb/host_model.sv
/*
 Host side: issues single register accesses, flagging serial activity around each.
 Assumes tasks are called from one process.
*/
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic clk_in,
	// Strobes toward the device
	output logic reg_write_out = 1'b0,
	output logic reg_read_out = 1'b0,
	output logic [7:0] reg_addr_out = 8'h00,
	output logic [7:0] reg_wdata_out = 8'h00,
	output logic serial_busy_out = 1'b0,
	// Read data
	input wire logic [7:0] reg_rdata_in
);
	// Released address and data lines show the inverse so stale values cannot pass; strobes drop to 0
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_in);
		serial_busy_out <= 1'b1;
		@(posedge clk_in);
		reg_write_out <= wr;
		reg_read_out <= !wr;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge clk_in);
		reg_write_out <= 1'b0;
		reg_read_out <= 1'b0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
		@(posedge clk_in);
		q = reg_rdata_in;
		serial_busy_out <= 1'b0;
	endtask
endmodule // host_model

// ===== tb/led_bypass_pwm_matrix_tb.sv
/*
 Self-checking bench for the PWM matrix, driving registers through the host model.
 Assumes the 20 MHz clock and the register map of the package.
*/
`timescale 1ns/1ps
module led_bypass_pwm_matrix_tb;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic vin_low = 1'b0;
	logic core_low = 1'b0;
	logic int_tick = 1'b0;
	logic ext_tick = 1'b0;
	logic ext_present = 1'b1;
	logic [11:0] addr_pin = 12'h000;
	logic [11:0] bin_pin = 12'h000;
	logic wr, rd, busy, spread;
	logic [7:0] addr, wdata, rdata, got;
	logic [3:0] dev_addr, bin_code;
	logic [11:0] bypass, cnt, off;
	int miscompares = 0;
	int compares = 0;
	always #25 clk_in = ~clk_in;
	host_model host_model_i (.clk_in(clk_in), .reg_write_out(wr), .reg_read_out(rd), .reg_addr_out(addr),
		.reg_wdata_out(wdata), .serial_busy_out(busy), .reg_rdata_in(rdata));
	led_bypass_pwm_matrix led_bypass_pwm_matrix_i (.clk_in(clk_in), .nrst_in(nrst_in),
		.input_reset_threshold_low_in(vin_low), .core_undervoltage_lockout_in(core_low),
		.reg_write_in(wr), .reg_read_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.serial_busy_in(busy), .ext_clk_tick_in(ext_tick), .ext_clk_present_in(ext_present),
		.int_clk_tick_in(int_tick), .spread_enable_out(spread), .address_resistor_pin_in(addr_pin),
		.binning_resistor_pin_in(bin_pin), .device_address_out(dev_addr), .binning_code_out(bin_code),
		.bypass_on_out(bypass));
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		host_model_i.access(1'b1, a, d, got);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		host_model_i.access(1'b0, a, 8'h00, got);
		check({4'h0, got}, {4'h0, e});
	endtask
	// Switch 0: delay 2, duty 3; switch 11: delay FFD, duty 5, sum past the wrap
	task automatic tick(input logic counts);
		@(posedge clk_in);
		int_tick <= 1'b1;
		@(posedge clk_in);
		int_tick <= 1'b0;
		if (counts) begin
			if (cnt == 12'h002)
				off[0] = 1'b1;
			else if (cnt > 12'h005)
				off[0] = 1'b0;
			if (cnt == 12'hFFD)
				off[11] = 1'b1;
			cnt = cnt + 12'h001;
		end
		@(negedge clk_in);
		@(negedge clk_in);
		check(bypass, ~off);
	endtask
	task automatic report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		cycles(40000);
		miscompares++;
		report_and_stop();
	end
	initial begin
		off = 12'h000;
		cycles(16);
		nrst_in <= 1'b1;
		cycles(4);
		check(bypass, 12'hFFF);
		rreg(8'h01, 8'h00);
		for (int k = 0; k < 16; k++) begin
			addr_pin <= {k[3:0], 8'hA5};
			bin_pin <= {~k[3:0], 8'h5A};
			cycles(5);
			check({8'h00, dev_addr}, {8'h00, k[3:0]});
			check({8'h00, bin_code}, {8'h00, ~k[3:0]});
		end
		rreg(8'h03, 8'h0F);
		$display("reset and pin test done");
		wreg(8'h20, 8'h02);
		wreg(8'h40, 8'h03);
		wreg(8'h36, 8'hFD);
		wreg(8'h37, 8'h0F);
		wreg(8'h56, 8'h05);
		rreg(8'h37, 8'h0F);
		wreg(8'h02, 8'h01);
		wreg(8'h01, 8'h01);
		repeat (3) tick(1'b0);
		repeat (3) begin
			ext_tick <= 1'b1;
			cycles(3);
			ext_tick <= 1'b0;
			cycles(3);
		end
		cycles(3);
		check(bypass, 12'hFFE);
		wreg(8'h01, 8'h00);
		cycles(3);
		check(bypass, 12'hFFF);
		ext_present <= 1'b0;
		wreg(8'h01, 8'h01);
		repeat (2) tick(1'b0);
		off = 12'h001;
		tick(1'b0);
		ext_present <= 1'b1;
		off = 12'h000;
		wreg(8'h01, 8'h00);
		$display("external clock test done");
		wreg(8'h02, 8'h00);
		wreg(8'h01, 8'h01);
		cnt = 12'h000;
		repeat (4200) tick(1'b1);
		$display("dimming test done");
		wreg(8'h02, 8'h02);
		cycles(6);
		check({11'h000, spread}, 12'h001);
		vin_low <= 1'b1;
		cycles(6);
		rreg(8'h01, 8'h01);
		core_low <= 1'b1;
		cycles(6);
		check(bypass, 12'hFFF);
		check({11'h000, spread}, 12'h000);
		rreg(8'h01, 8'h00);
		rreg(8'h02, 8'h00);
		rreg(8'h40, 8'h00);
		rreg(8'h7F, 8'h00);
		$display("supply test done");
		report_and_stop();
	end
endmodule // led_bypass_pwm_matrix_tb
